// file: rtl/ispd_pkg.sv
// Purpose: shared constants and types of the input source power-up block
// Assumes: pclk at 10 MHz, apb with 32-bit data
// Notes: analog comparators arrive as one packed struct of levels
package ispd_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned GATE_DLY_MS = 220;   // supply qualify time
  localparam int unsigned LOAD_TEST_MS = 30;   // test load window
  localparam int unsigned RETRY_MS = 2000;     // retry period, two seconds
  localparam int unsigned INT_PULSE_US = 100;  // interrupt low time
  localparam int unsigned GATE_DLY_CYC = GATE_DLY_MS * CYC_PER_MS;
  localparam int unsigned LOAD_TEST_CYC = LOAD_TEST_MS * CYC_PER_MS;
  localparam int unsigned RETRY_CYC = RETRY_MS * CYC_PER_MS;
  localparam int unsigned INT_PULSE_CYC = INT_PULSE_US * CYC_PER_US;
  localparam int unsigned TMR_W = 25;          // holds the longest count
  localparam int unsigned INT_W = 12;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ILIM_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  // ctrl fields
  localparam int unsigned CTRL_KICK_BIT = 0;
  localparam int unsigned CTRL_FORCE_BIT = 1;
  localparam int unsigned CTRL_DP_LSB = 2;
  localparam int unsigned CTRL_DM_LSB = 4;
  localparam int unsigned CTRL_BSW_OFF_BIT = 6;
  // status fields
  localparam int unsigned ST_IGOOD_BIT = 0;
  localparam int unsigned ST_PGOOD_BIT = 1;
  localparam int unsigned ST_TYPE_LSB = 2;
  localparam int unsigned ST_HOST_BIT = 5;
  localparam int unsigned ST_GATE_BIT = 6;
  localparam int unsigned ST_HIZ_BIT = 7;
  localparam int unsigned ST_SLEEP_BIT = 8;
  localparam int unsigned ST_STATE_LSB = 9;

  // ==========================================================
  // current limit code: 100 mA per step from 100 mA
  localparam int unsigned ILIM_OFS_MA = 100;
  localparam int unsigned ILIM_LSB_MA = 100;
  localparam int unsigned LIM_SDP_MA = 500;
  localparam int unsigned LIM_ADAPT_MA = 2400;
  localparam int unsigned LIM_CDP_MA = 1500;
  localparam int unsigned LIM_DIV1_MA = 2100;
  localparam int unsigned LIM_DIV2_MA = 2000;
  localparam int unsigned LIM_DIV3_MA = 1000;
  localparam int unsigned LIM_DIV4_MA = 2400;

  // source type status codes
  localparam logic [2:0] TYPE_NONE = 3'h0;
  localparam logic [2:0] TYPE_SDP = 3'h1;
  localparam logic [2:0] TYPE_ADAPT = 3'h2;
  localparam logic [2:0] TYPE_CDP = 3'h3;
  localparam logic [2:0] TYPE_UNKNOWN = 3'h5;

  // analog detector answers
  localparam logic [2:0] BC_SDP = 3'h0;
  localparam logic [2:0] BC_CDP = 3'h1;
  localparam logic [2:0] BC_DCP = 3'h2;
  localparam logic [2:0] BC_DCD_TMO = 3'h3;
  localparam logic [1:0] WIN_1P2 = 2'h1;
  localparam logic [1:0] WIN_2P0 = 2'h2;
  localparam logic [1:0] WIN_2P7 = 2'h3;
  localparam logic [1:0] DRV_HIZ = 2'h0;

  typedef enum logic [2:0] {
    S_HIZ = 3'b000,
    S_LOAD_TEST = 3'b001,
    S_RETRY = 3'b010,
    S_DETECT = 3'b011,
    S_RUN = 3'b100
  } ispd_state_type;

  // comparator and pin levels from the analog side
  typedef struct packed {
    logic supply_ok;        // max(vin, vbat) above uvlo
    logic vac_present;
    logic vac_above_sleepz;
    logic vbus_below_sleep;
    logic boost_mode;
    logic vbus_below_ov;
    logic vbus_above_min;
    logic bat_above_depl;
    logic bat_overcurrent;
    logic supplement;
    logic select_pin;
    logic bc_done;
    logic [2:0] bc_class;
    logic [1:0] dp_win;
    logic [1:0] dm_win;
  } ispd_sense_type;

  typedef struct packed {
    logic [4:0] code;
    logic [2:0] stype;
  } ispd_result_type;

endpackage

// file: rtl/ispd_top.sv
// Purpose: power-up sequencing and source detection with apb registers
// Assumes: comparators are asynchronous levels; bc_class and windows
//   stay stable while bc_done is high
// Notes: all sequencing delays are counted on pclk

// Summary of operation
// R1: supply under uvlo resets state, settings and results
// R2: battery only: switch closed, gate supply off
// R3: supplement overcurrent opens switch, sets off bit
// R4: switch stays open until input or re-enable
// R5: regulator, qualify, detect, limit, then converter
// R6: gate supply after conditions hold 220ms
// R7: 25mA load for 30ms, within ov and min
// R8: failed qualification retried every two seconds
// R9: pass sets input good, pulses interrupt
// R10: detection only when powered and input good
// R11: detection loads limit, good, type, interrupt
// R12: limit code always applied, host may overwrite
// R13: default mode follows pin, host needs force
// R14: pin high 500mA/001, low 2400mA/010
// R15: bc1.2: sdp 500, cdp 1500, dcp 2400
// R16: timeout: dividers give 2.1, 2, 1, 2.4A
// R17: force starts detection, clears when done
// R18: d+/d- drive levels ignored during detection
// R19: sleep stops converter switching
// R20: high impedance: blocking switch and regulator off
// R21: watchdog kick enters host mode
// R22: delays counted on the internal clock
// R23: interrupt is one fixed low pulse
module ispd_top
  import ispd_pkg::*;
#(
  parameter int unsigned GATE_DLY_CYC_P = GATE_DLY_CYC,
  parameter int unsigned LOAD_TEST_CYC_P = LOAD_TEST_CYC,
  parameter int unsigned RETRY_CYC_P = RETRY_CYC,
  parameter bit DPDM_VARIANT = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ispd_sense_type sense_async,
  output logic gate_supply_on,
  output logic blocking_switch_on,
  output logic battery_switch_on,
  output logic test_load_on,
  output logic converter_on,
  output logic bc_detect_run,
  output logic [4:0] input_current_limit,
  output logic [1:0] dplus_level,
  output logic dplus_oe,
  output logic [1:0] dminus_level,
  output logic dminus_oe,
  output logic host_interrupt_n_o,
  output logic host_interrupt_n_oe
);
  // ==========================================================
  // parameter checks
  generate
    if (GATE_DLY_CYC_P < 1 || GATE_DLY_CYC_P >= (1 << TMR_W))
      $error("gate delay count out of range");
    if (LOAD_TEST_CYC_P < 1 || LOAD_TEST_CYC_P >= (1 << TMR_W))
      $error("load test count out of range");
    if (RETRY_CYC_P < 1 || RETRY_CYC_P >= (1 << TMR_W))
      $error("retry count out of range");
  endgenerate
  localparam logic [TMR_W-1:0] GATE_LAST = TMR_W'(GATE_DLY_CYC_P - 1);
  localparam logic [TMR_W-1:0] LOAD_LAST = TMR_W'(LOAD_TEST_CYC_P - 1);
  localparam logic [TMR_W-1:0] RETRY_LAST = TMR_W'(RETRY_CYC_P - 1);
  localparam logic [INT_W-1:0] INT_LAST = INT_W'(INT_PULSE_CYC - 1);
  localparam logic [4:0] ILIM_RESET = 5'h04;  // 500 ma after reset
  // converts a limit in ma to the five-bit code
  function automatic logic [4:0] ma_code(input int unsigned ma);
    ma_code = 5'((ma - ILIM_OFS_MA) / ILIM_LSB_MA);
  endfunction
  // classifies the analog detector answer
  function automatic ispd_result_type bc_map(input logic [2:0] cls,
      input logic [1:0] dp, input logic [1:0] dm);
    bc_map = '{code: ma_code(LIM_SDP_MA), stype: TYPE_UNKNOWN};
    case (cls)
      BC_SDP: bc_map = '{code: ma_code(LIM_SDP_MA), stype: TYPE_SDP};
      BC_CDP: bc_map = '{code: ma_code(LIM_CDP_MA), stype: TYPE_CDP};
      BC_DCP: bc_map = '{code: ma_code(LIM_ADAPT_MA), stype: TYPE_ADAPT};
      BC_DCD_TMO: begin
        // non-standard dividers by d+/d- windows; else unknown 500 ma
        if (dp == WIN_2P7 && dm == WIN_2P0) begin
          bc_map = '{code: ma_code(LIM_DIV1_MA), stype: TYPE_ADAPT};
        end else if (dp == WIN_1P2 && dm == WIN_1P2) begin
          bc_map = '{code: ma_code(LIM_DIV2_MA), stype: TYPE_ADAPT};
        end else if (dp == WIN_2P0 && dm == WIN_2P7) begin
          bc_map = '{code: ma_code(LIM_DIV3_MA), stype: TYPE_ADAPT};
        end else if (dp == WIN_2P7 && dm == WIN_2P7) begin
          bc_map = '{code: ma_code(LIM_DIV4_MA), stype: TYPE_ADAPT};
        end
      end
      default: bc_map = '{code: ma_code(LIM_SDP_MA), stype: TYPE_UNKNOWN};
    endcase
  endfunction
  // ==========================================================
  // synchronisers for all analog levels
  ispd_sense_type sense_meta_reg;  // first stage, read only by second
  ispd_sense_type sense;           // second stage, safe to use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_meta_reg <= '0;
      sense <= '0;
    end else begin
      sense_meta_reg <= sense_async;
      sense <= sense_meta_reg;
    end
  end
  // soft power-on reset while the selected supply is under uvlo
  logic por;
  assign por = !sense.supply_ok;  // see R1
  // ==========================================================
  // declarations
  ispd_state_type state_reg;
  logic [TMR_W-1:0] timer_reg;
  logic host_mode_reg;          // set by watchdog kick
  logic force_reg;              // force source detection
  logic [1:0] dp_set_reg;
  logic [1:0] dm_set_reg;
  logic bsw_off_reg;            // battery switch forced open
  logic [4:0] ilim_reg;
  logic igood_reg;
  logic pgood_reg;
  logic [2:0] stype_reg;
  logic int_req;                // one-cycle notification request
  logic [INT_W-1:0] int_cnt_reg;
  logic int_act_reg;
  logic gate_cond;
  logic src_ok;
  logic sleep;
  logic detect_done;
  ispd_result_type det_res;
  ispd_result_type pin_res;
  logic wr;
  logic setup_rd;
  logic mapped;

  // gate supply conditions in buck or boost direction
  assign gate_cond = sense.vac_present && (sense.boost_mode ?
      sense.vbus_below_sleep : sense.vac_above_sleepz);  // see R6
  assign src_ok = sense.vbus_below_ov && sense.vbus_above_min;  // see R7
  assign sleep = !sense.vac_above_sleepz;  // see R19
  // pin variant answer
  assign pin_res = sense.select_pin ?  // see R14
      ispd_result_type'{code: ma_code(LIM_SDP_MA), stype: TYPE_SDP} :
      ispd_result_type'{code: ma_code(LIM_ADAPT_MA), stype: TYPE_ADAPT};
  assign det_res = DPDM_VARIANT ?
      bc_map(sense.bc_class, sense.dp_win, sense.dm_win) :
      pin_res;  // see R15 see R16
  // detection finishes: d+/d- needs the analog done, pin needs force
  // in host mode, otherwise samples at once
  assign detect_done = (state_reg == S_DETECT) && (DPDM_VARIANT ?
      sense.bc_done : (!host_mode_reg || force_reg));  // see R13 see R10
  // ==========================================================
  // apb decode: zero wait states, unmapped offsets answer an error
  assign wr = psel && penable && pwrite;
  assign setup_rd = psel && !penable && !pwrite;
  assign mapped = (paddr == CTRL_OFS) || (paddr == ILIM_OFS) ||
      (paddr == STATUS_OFS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  // read data captured in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup_rd) begin
      prdata <= '0;
      case (paddr)
        CTRL_OFS: begin
          // kick reads as zero
          prdata[CTRL_FORCE_BIT] <= force_reg;
          prdata[CTRL_DP_LSB +: 2] <= dp_set_reg;
          prdata[CTRL_DM_LSB +: 2] <= dm_set_reg;
          prdata[CTRL_BSW_OFF_BIT] <= bsw_off_reg;
        end
        ILIM_OFS: prdata[4:0] <= ilim_reg;
        STATUS_OFS: begin
          prdata[ST_IGOOD_BIT] <= igood_reg;
          prdata[ST_PGOOD_BIT] <= pgood_reg;
          prdata[ST_TYPE_LSB +: 3] <= stype_reg;
          prdata[ST_HOST_BIT] <= host_mode_reg;
          prdata[ST_GATE_BIT] <= gate_supply_on;
          prdata[ST_HIZ_BIT] <= !gate_supply_on;
          prdata[ST_SLEEP_BIT] <= sleep;
          prdata[ST_STATE_LSB +: 3] <= state_reg;
        end
        default: prdata <= '0;  // unmapped reads zero
      endcase
    end
  end
  // ==========================================================
  // power-up sequencer with one shared delay counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_HIZ;
      timer_reg <= '0;
    end else if (por) begin
      state_reg <= S_HIZ;  // see R1
      timer_reg <= '0;
    end else if (state_reg != S_HIZ && !gate_cond) begin
      // input lost: drop back to high impedance
      state_reg <= S_HIZ;  // see R20
      timer_reg <= '0;
    end else begin
      case (state_reg)
        S_HIZ: begin
          // conditions must hold without a break for the full delay
          if (!gate_cond) begin
            timer_reg <= '0;
          end else if (timer_reg == GATE_LAST) begin
            timer_reg <= '0;
            state_reg <= S_LOAD_TEST;  // see R6 see R22
          end else begin
            timer_reg <= timer_reg + 1'b1;
          end
        end
        S_LOAD_TEST: begin
          if (!src_ok) begin
            timer_reg <= '0;
            state_reg <= S_RETRY;  // see R8
          end else if (timer_reg == LOAD_LAST) begin
            timer_reg <= '0;
            state_reg <= S_DETECT;  // see R7 see R5
          end else begin
            timer_reg <= timer_reg + 1'b1;
          end
        end
        S_RETRY: begin
          // counts from the failed test to the next one
          if (timer_reg == RETRY_LAST) begin
            timer_reg <= '0;
            state_reg <= S_LOAD_TEST;  // see R8 see R22
          end else begin
            timer_reg <= timer_reg + 1'b1;
          end
        end
        S_DETECT: begin
          if (detect_done) begin
            state_reg <= S_RUN;  // see R5
          end
        end
        S_RUN: begin
          // a forced detection reruns the type detection
          if (host_mode_reg && force_reg) begin
            state_reg <= S_DETECT;  // see R17
          end
        end
        default: begin
          state_reg <= S_HIZ;
          timer_reg <= '0;
        end
      endcase
    end
  end
  // ==========================================================
  // mode and drive settings written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_mode_reg <= 1'b0;
      dp_set_reg <= DRV_HIZ;
      dm_set_reg <= DRV_HIZ;
    end else if (por) begin
      host_mode_reg <= 1'b0;
      dp_set_reg <= DRV_HIZ;
      dm_set_reg <= DRV_HIZ;
    end else if (wr && paddr == CTRL_OFS) begin
      if (pwdata[CTRL_KICK_BIT]) begin
        host_mode_reg <= 1'b1;  // see R21
      end
      dp_set_reg <= pwdata[CTRL_DP_LSB +: 2];
      dm_set_reg <= pwdata[CTRL_DM_LSB +: 2];
    end
  end

  // force bit: cleared by hardware when the detection completes;
  // a write of one in that same cycle wins so the request is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_reg <= 1'b0;
    end else if (por) begin
      force_reg <= 1'b0;
    end else if (wr && paddr == CTRL_OFS && host_mode_reg &&
        pwdata[CTRL_FORCE_BIT]) begin
      force_reg <= 1'b1;  // see R17
    end else if (detect_done || state_reg == S_HIZ) begin
      force_reg <= 1'b0;  // see R17
    end
  end

  // battery switch off bit: the hardware set wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bsw_off_reg <= 1'b0;
    end else if (por) begin
      bsw_off_reg <= 1'b0;
    end else if (sense.supplement && sense.bat_overcurrent) begin
      bsw_off_reg <= 1'b1;  // see R3
    end else if (state_reg == S_HIZ && gate_cond) begin
      bsw_off_reg <= 1'b0;  // input applied, see R4
    end else if (wr && paddr == CTRL_OFS) begin
      bsw_off_reg <= pwdata[CTRL_BSW_OFF_BIT];  // re-enable, see R4
    end
  end
  // ==========================================================
  // detection results and flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      igood_reg <= 1'b0;
      pgood_reg <= 1'b0;
      stype_reg <= TYPE_NONE;
    end else if (por || state_reg == S_HIZ) begin
      igood_reg <= 1'b0;
      pgood_reg <= 1'b0;
      stype_reg <= TYPE_NONE;
    end else begin
      if (state_reg == S_LOAD_TEST && src_ok &&
          timer_reg == LOAD_LAST) begin
        igood_reg <= 1'b1;  // see R9
      end
      if (detect_done) begin
        pgood_reg <= 1'b1;  // see R11
        stype_reg <= det_res.stype;
      end else if (!DPDM_VARIANT && !host_mode_reg &&
          state_reg == S_RUN) begin
        stype_reg <= pin_res.stype;  // see R13
      end
    end
  end

  // limit code: a host write wins over a hardware load in one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ilim_reg <= ILIM_RESET;
    end else if (por) begin
      ilim_reg <= ILIM_RESET;
    end else if (wr && paddr == ILIM_OFS) begin
      ilim_reg <= pwdata[4:0];  // see R12
    end else if (detect_done) begin
      ilim_reg <= det_res.code;  // see R11
    end else if (!DPDM_VARIANT && !host_mode_reg &&
        state_reg == S_RUN) begin
      ilim_reg <= pin_res.code;  // default mode tracks pin, see R13
    end
  end
  // ==========================================================
  // host interrupt: one fixed-length low pulse per notification;
  // a request during a pulse merges into it
  assign int_req = (state_reg == S_LOAD_TEST && src_ok &&
      timer_reg == LOAD_LAST) || detect_done;  // see R9 see R11
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_act_reg <= 1'b0;
      int_cnt_reg <= '0;
    end else if (int_req && !int_act_reg) begin
      int_act_reg <= 1'b1;  // see R23
      int_cnt_reg <= '0;
    end else if (int_act_reg) begin
      if (int_cnt_reg == INT_LAST) begin
        int_act_reg <= 1'b0;
      end else begin
        int_cnt_reg <= int_cnt_reg + 1'b1;
      end
    end
  end
  // open drain: enable pulls the line low, released otherwise
  assign host_interrupt_n_o = 1'b0;
  assign host_interrupt_n_oe = int_act_reg;  // see R23
  // ==========================================================
  // power switch and drive outputs
  assign gate_supply_on = (state_reg != S_HIZ);  // see R6 see R2
  assign blocking_switch_on = gate_supply_on;  // see R20
  assign test_load_on = (state_reg == S_LOAD_TEST);  // see R7
  // converter waits for a limit and stops in sleep
  assign converter_on = (state_reg == S_RUN) && !sleep;  // see R19
  assign battery_switch_on = sense.bat_above_depl && !bsw_off_reg &&
      !(sense.supplement && sense.bat_overcurrent);  // see R2 see R3
  assign input_current_limit = ilim_reg;  // see R12
  assign bc_detect_run = DPDM_VARIANT && (state_reg == S_DETECT);

  // drive settings take effect only outside detection
  assign dplus_level = dp_set_reg;
  assign dminus_level = dm_set_reg;
  assign dplus_oe = !bc_detect_run && dp_set_reg != DRV_HIZ;  // see R18
  assign dminus_oe = !bc_detect_run && dm_set_reg != DRV_HIZ;  // see R18
endmodule

// file: test/ispd_src_model.sv
// Purpose: input source and battery side seen by the sequencer
// Assumes: pin-select variant, no d+/d- classifier activity
// Notes: levels only; the bench steers plug, sag, pin and overload
module ispd_src_model
  import ispd_pkg::*;
(
  input wire logic plug,
  input wire logic sag,
  input wire logic sel,
  input wire logic ocp,
  output ispd_sense_type sense
);
  // ==========================================================
  // comparator levels
  // battery always healthy so overload and battery-only cases stay reachable
  always_comb begin
    sense = '0;
    sense.supply_ok = 1'b1;
    sense.vac_present = plug;
    sense.vac_above_sleepz = plug;
    sense.vbus_below_ov = 1'b1;
    sense.vbus_above_min = plug & ~sag; // a sagging source fails the load
    sense.bat_above_depl = 1'b1;
    sense.bat_overcurrent = ocp;
    sense.supplement = ocp;
    sense.select_pin = sel;
  end
endmodule

// file: test/ispd_chk.sv
// Purpose: port-level timing checks of the power-up sequencer
// Assumes: one clock domain, sense levels pass a 2-flop sync
// Notes: counters track consecutive qualify and interrupt cycles
module ispd_chk
  import ispd_pkg::*;
#(
  parameter int unsigned GATE_DLY_CYC_P = 50
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire ispd_sense_type sense_async,
  input wire logic gate_supply_on,
  input wire logic battery_switch_on,
  input wire logic test_load_on,
  input wire logic converter_on,
  input wire logic bc_detect_run,
  input wire logic [4:0] input_current_limit,
  input wire logic [1:0] dplus_level,
  input wire logic dplus_oe,
  input wire logic dminus_oe,
  input wire logic host_interrupt_n_oe
);
  // ==========================================================
  // helpers
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic gc; // raw gate condition, buck mode
  logic ocp; // overload while supplementing
  int unsigned gc_cnt; // consecutive cycles of gc
  int unsigned int_cnt; // cycles the interrupt pin is pulled
  assign gc = sense_async.vac_present & sense_async.vac_above_sleepz;
  assign ocp = sense_async.bat_overcurrent & sense_async.supplement;
  // counters restart on any gap so a glitch cannot satisfy the delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gc_cnt <= 0;
      int_cnt <= 0;
    end else begin
      gc_cnt <= gc ? gc_cnt + 1 : 0;
      int_cnt <= host_interrupt_n_oe ? int_cnt + 1 : 0;
    end
  end
  sequence s_ocp_held;
    ocp [*3];
  endsequence
  // ==========================================================
  // assertions
  a_ocp_open: assert property (s_ocp_held |-> !battery_switch_on)
    else $error("switch not opened on overload");
  a_gate_delay: assert property ($rose(gate_supply_on) |->
    gc_cnt >= GATE_DLY_CYC_P) else $error("gate supply on too early");
  a_hiz_drop: assert property ((!gc) [*4] |->
    !gate_supply_on && !converter_on) else $error("not in hiz");
  a_load_order: assert property (test_load_on |->
    gate_supply_on && !converter_on) else $error("load test out of order");
  a_sleep_stop: assert property ((!sense_async.vac_above_sleepz) [*3] |->
    !converter_on) else $error("switching in sleep");
  a_int_len: assert property ($fell(host_interrupt_n_oe) |->
    int_cnt >= INT_PULSE_CYC && int_cnt <= 2 * INT_PULSE_CYC)
    else $error("interrupt pulse length");
  a_bc_quiet: assert property (bc_detect_run |->
    !dplus_oe && !dminus_oe) else $error("d+/d- driven in detection");
  a_dp_drive: assert property (dplus_level != DRV_HIZ && !bc_detect_run
    |-> dplus_oe) else $error("d+ not driven");
  a_ilim_wr: assert property (psel && penable && pwrite &&
    paddr == ILIM_OFS |=> input_current_limit == $past(pwdata[4:0]))
    else $error("limit write lost");
endmodule

// file: test/tb_top.sv
// Purpose: self-checking bench of the power-up sequencer
// Assumes: pin variant, shortened delays 50/20/100 cycles
// Notes: apb master holds each request until pready is sampled
module tb_top
  import ispd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // signals
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, e, gate, blk, bsw, tload, conv, bcr;
  logic plug = 0, sag = 0, sel = 1, ocp = 0, dpoe, dmoe, into, intoe;
  logic [4:0] ilim;
  logic [1:0] dpl, dml;
  ispd_sense_type sense;
  int fails = 0, num_checks = 0, i, int_seen = 0;
  always #50 pclk = ~pclk;
  always @(posedge pclk) if (intoe === 1'b1) int_seen++;
  ispd_src_model ispd_src_model_i (.plug(plug), .sag(sag), .sel(sel),
    .ocp(ocp), .sense(sense));
  ispd_top #(.GATE_DLY_CYC_P(50), .LOAD_TEST_CYC_P(20),
    .RETRY_CYC_P(100), .DPDM_VARIANT(1'b0)) ispd_top_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sense_async(sense), .gate_supply_on(gate),
    .blocking_switch_on(blk), .battery_switch_on(bsw),
    .test_load_on(tload), .converter_on(conv), .bc_detect_run(bcr),
    .input_current_limit(ilim), .dplus_level(dpl), .dplus_oe(dpoe),
    .dminus_level(dml), .dminus_oe(dmoe), .host_interrupt_n_o(into),
    .host_interrupt_n_oe(intoe));
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; waits for pready, no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic end_sim();
    if (fails == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    apb(0, ILIM_OFS, 0); chk(r, 32'h4);
    apb(0, 8'h0c, 0); chk(r, 0); chk(e, 1);
    chk({bsw, gate}, 2'b10);
  endtask
  task automatic t_power();
    @(posedge pclk); plug <= 1; sag <= 1;
    for (i = 0; gate !== 1'b1 && i < 200; i++) @(posedge pclk);
    chk(i >= 50 && i <= 60, 1);
    repeat (6) @(posedge pclk);
    apb(0, STATUS_OFS, 0); chk(r[11:9], 3'h2);
    sag <= 0;
    for (i = 0; conv !== 1'b1 && i < 400; i++) @(posedge pclk);
    apb(0, STATUS_OFS, 0); chk(r, 32'h847);
    chk(ilim, 5'h04);
  endtask
  task automatic t_pin();
    sel <= 0;
    repeat (2200) @(posedge pclk);
    chk(ilim, 5'h17);
    apb(0, STATUS_OFS, 0); chk(r[4:2], 3'h2);
    chk(int_seen, INT_PULSE_CYC);
  endtask
  task automatic t_host();
    apb(1, CTRL_OFS, 32'h1); apb(0, STATUS_OFS, 0); chk(r[5], 1);
    apb(1, ILIM_OFS, 32'h0a); sel <= 1;
    repeat (6) @(posedge pclk);
    chk(ilim, 5'h0a);
    apb(1, CTRL_OFS, 32'h2e);
    repeat (8) @(posedge pclk);
    chk(ilim, 5'h04);
    apb(0, CTRL_OFS, 0); chk(r[1], 0);
    chk({dpoe, dpl, dmoe, dml, bcr}, 7'b1111100);
  endtask
  task automatic t_ocp();
    ocp <= 1; repeat (4) @(posedge pclk); chk(bsw, 0);
    ocp <= 0; repeat (4) @(posedge pclk); chk(bsw, 0);
    apb(0, CTRL_OFS, 0); chk(r[6], 1);
    apb(1, CTRL_OFS, 0); repeat (2) @(posedge pclk); chk(bsw, 1);
  endtask
  task automatic t_unplug();
    plug <= 0; repeat (5) @(posedge pclk);
    chk({gate, conv, tload, blk, into}, 5'b00000);
    apb(0, STATUS_OFS, 0); chk({r[7], r[0]}, 2'b10);
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    repeat (4) @(posedge pclk);
    t_reset(); t_power(); t_pin(); t_host(); t_ocp(); t_unplug();
    end_sim();
  end
  initial begin
    #(100 * 20000);
    fails++;
    end_sim();
  end
endmodule
bind ispd_top ispd_chk #(.GATE_DLY_CYC_P(GATE_DLY_CYC_P)) ispd_chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .sense_async(sense_async), .gate_supply_on(gate_supply_on),
  .battery_switch_on(battery_switch_on), .test_load_on(test_load_on),
  .converter_on(converter_on), .bc_detect_run(bc_detect_run),
  .input_current_limit(input_current_limit), .dplus_level(dplus_level),
  .dplus_oe(dplus_oe), .dminus_oe(dminus_oe),
  .host_interrupt_n_oe(host_interrupt_n_oe));
